// file: pfs_defs.svh
// constants for the function status register block
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

`define PFS_STATUS_OFFSET 8'h06
`define PFS_STATUS_RESET  16'h0230
`define PFS_BIT_PAR_DET   15
`define PFS_BIT_SERR_OUT  14
`define PFS_BIT_MSTR_ABT  13
`define PFS_BIT_TABORT_R  12
`define PFS_BIT_TABORT_S  11
`define PFS_DEVSEL_HI     10
`define PFS_DEVSEL_LO     9
`define PFS_DEVSEL_MEDIUM 2'h1
`define PFS_BIT_MDPAR     8
`define PFS_BIT_FBB       7
`define PFS_BIT_USR_FEAT  6
`define PFS_BIT_HICLK     5
`define PFS_BIT_CAPS      4
`define PFS_BIT_INTSTAT   3

`endif

// file: pfs_pkg.sv
// types shared by the function status register block
package pfs_pkg;

	// bus events seen in one clock, each a one-cycle pulse
	typedef struct packed {
		logic addr_parity_err;
		logic data_parity_err;
		logic serr_signaled;
		logic master_abort_rcvd;
		logic target_abort_rcvd;
		logic target_abort_sent;
		logic perr_seen;
		logic was_bus_master;
	} pfs_event_s;

	// configuration write toward the register
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [1:0]  be;
		logic [15:0] data;
	} pfs_cfg_wr_s;

	typedef enum logic [1:0] {
		PFS_IRQ_IDLE,
		PFS_IRQ_ASSERT
	} pfs_irq_e;

endpackage

// file: pfs_sticky_flag.sv
// one sticky error flag: hardware sets, write of 1 clears, set wins
`timescale 1ns/1ps
module pfs_sticky_flag (
	input  wire logic mclk_i,
	input  wire logic arst_n_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (clr_i) begin
			flag_o <= 1'b0;
		end
	end
endmodule // pfs_sticky_flag

// file: pfs_irq_gate.sv
// drives the interrupt line from status and the disable control
`timescale 1ns/1ps
module pfs_irq_gate
	import pfs_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic arst_n_i,
	input  wire logic int_status_i,
	input  wire logic int_disable_i,
	output logic      intx_o
);
	pfs_irq_e state_q;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= PFS_IRQ_IDLE;
		end else begin
			case (state_q)
				PFS_IRQ_IDLE: begin
					if (int_status_i && !int_disable_i)
						state_q <= PFS_IRQ_ASSERT;
				end
				PFS_IRQ_ASSERT: begin
					if (!int_status_i || int_disable_i)
						state_q <= PFS_IRQ_IDLE;
				end
				default: state_q <= PFS_IRQ_IDLE;
			endcase
		end
	end

	assign intx_o = (state_q == PFS_IRQ_ASSERT);
endmodule // pfs_irq_gate

// file: pfs_status_reg.sv
// function status register of the configuration header
//
// Behaviour
// - address or data parity error sets detected parity flag, bit 15
// - system error signaled while enabled sets bit 14
// - own cycle ending in master abort sets bit 13
// - own cycle ended by target abort sets bit 12
// - target abort issued as target sets bit 11
// - bits 10 to 9 read 01b, medium select timing
// - bit 8 set on perr while bus master and parity response enabled
// - bits 7, 6 and 2 to 0 read zero
// - bit 5 reads one, high clock capable
// - bit 4 reads one, capability chain present
// - bit 3 shows pending interrupt; interrupt out only when not disabled
// - interrupt status keeps tracking while disabled
// - system error output driven only while its enable is one
`timescale 1ns/1ps
`include "pfs_defs.svh"
module pfs_status_reg
	import pfs_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        arst_n_i,
	input  wire pfs_event_s  evt_i,
	input  wire logic        int_pending_i,
	input  wire logic        parity_response_enable_i,
	input  wire logic        system_error_enable_i,
	input  wire logic        int_disable_i,
	input  wire pfs_cfg_wr_s cfg_wr_i,
	input  wire logic        cfg_rd_i,
	input  wire logic [7:0]  cfg_rd_addr_i,
	output logic [15:0]      cfg_rd_data_o,
	output logic             intx_o,
	output logic             serr_o,
	output logic             serr_oe_o
);
	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	logic        hit_w;
	logic [15:0] clr_w;
	logic [15:0] set_w;
	logic [15:0] status_w;
	logic        int_status_q;
	logic        serr_q;

	function automatic logic [15:0] lane_mask(input logic [1:0] be);
		lane_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	assign hit_w = cfg_wr_i.wr && (cfg_wr_i.addr == `PFS_STATUS_OFFSET);
	assign clr_w = hit_w ? (cfg_wr_i.data & lane_mask(cfg_wr_i.be))
	                     : 16'h0000;

	// ----------------------------------------------------------------
	// event to set terms
	// ----------------------------------------------------------------
	always_comb begin
		set_w = 16'h0000;
		set_w[`PFS_BIT_PAR_DET]  = evt_i.addr_parity_err
		                         | evt_i.data_parity_err;
		set_w[`PFS_BIT_SERR_OUT] = evt_i.serr_signaled
		                         & system_error_enable_i;
		set_w[`PFS_BIT_MSTR_ABT] = evt_i.master_abort_rcvd;
		set_w[`PFS_BIT_TABORT_R] = evt_i.target_abort_rcvd;
		set_w[`PFS_BIT_TABORT_S] = evt_i.target_abort_sent;
		set_w[`PFS_BIT_MDPAR] = evt_i.perr_seen & evt_i.was_bus_master
		                      & parity_response_enable_i;
	end

	// ----------------------------------------------------------------
	// sticky flags
	// ----------------------------------------------------------------
	logic [5:0] flag_w;
	localparam int FIDX [6] = '{`PFS_BIT_PAR_DET, `PFS_BIT_SERR_OUT,
		`PFS_BIT_MSTR_ABT, `PFS_BIT_TABORT_R, `PFS_BIT_TABORT_S,
		`PFS_BIT_MDPAR};

	for (genvar g = 0; g < 6; g++) begin : g_flag
		pfs_sticky_flag u_flag (
			.mclk_i   (mclk_i),
			.arst_n_i (arst_n_i),
			.set_i    (set_w[FIDX[g]]),
			.clr_i    (clr_w[FIDX[g]]),
			.flag_o   (flag_w[g])
		);
	end

	// interrupt status follows the source regardless of the disable
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			int_status_q <= 1'b0;
		end else begin
			int_status_q <= int_pending_i;
		end
	end

	// ----------------------------------------------------------------
	// read value
	// ----------------------------------------------------------------
	always_comb begin
		status_w = 16'h0000;
		status_w[`PFS_BIT_PAR_DET]  = flag_w[0];
		status_w[`PFS_BIT_SERR_OUT] = flag_w[1];
		status_w[`PFS_BIT_MSTR_ABT] = flag_w[2];
		status_w[`PFS_BIT_TABORT_R] = flag_w[3];
		status_w[`PFS_BIT_TABORT_S] = flag_w[4];
		status_w[`PFS_BIT_MDPAR]    = flag_w[5];
		status_w[`PFS_DEVSEL_HI:`PFS_DEVSEL_LO] = `PFS_DEVSEL_MEDIUM;
		status_w[`PFS_BIT_HICLK]    = 1'b1;
		status_w[`PFS_BIT_CAPS]     = 1'b1;
		status_w[`PFS_BIT_INTSTAT]  = int_status_q;
	end

	// registered read data: one cycle after the read strobe
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_rd_data_o <= 16'h0000;
		end else if (cfg_rd_i) begin
			cfg_rd_data_o <= (cfg_rd_addr_i == `PFS_STATUS_OFFSET)
			                 ? status_w : 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	pfs_irq_gate u_irq (
		.mclk_i        (mclk_i),
		.arst_n_i      (arst_n_i),
		.int_status_i  (int_status_q),
		.int_disable_i (int_disable_i),
		.intx_o        (intx_o)
	);

	// system error driver is enabled only under its enable control
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			serr_q    <= 1'b0;
			serr_oe_o <= 1'b0;
		end else begin
			serr_q    <= 1'b0; // open drain: the level is always low
			serr_oe_o <= evt_i.serr_signaled & system_error_enable_i;
		end
	end
	assign serr_o = serr_q; // only the enable ever toggles the pin

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_write_one_clear(int b);
		hit_w && cfg_wr_i.data[b] && cfg_wr_i.be[b/8] && !set_w[b];
	endsequence

	property p_par_set;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(evt_i.addr_parity_err || evt_i.data_parity_err) |=> flag_w[0];
	endproperty
	a_par_set: assert property (p_par_set)
		else $error("parity flag not set");

	property p_serr_flag;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(!flag_w[1] && !(evt_i.serr_signaled && system_error_enable_i))
		|=> !flag_w[1];
	endproperty
	a_serr_flag: assert property (p_serr_flag)
		else $error("system error flag set without cause");

	property p_received_master_abort_flag;
		@(posedge mclk_i) disable iff (!arst_n_i)
		evt_i.master_abort_rcvd |=> flag_w[2];
	endproperty
	a_received_master_abort_flag: assert property (p_received_master_abort_flag)
		else $error("master abort flag not set");

	property p_tabort_r;
		@(posedge mclk_i) disable iff (!arst_n_i)
		evt_i.target_abort_rcvd |=> flag_w[3];
	endproperty
	a_tabort_r: assert property (p_tabort_r)
		else $error("received target abort flag not set");

	property p_tabort_s;
		@(posedge mclk_i) disable iff (!arst_n_i)
		evt_i.target_abort_sent |=> flag_w[4];
	endproperty
	a_tabort_s: assert property (p_tabort_s)
		else $error("signaled target abort flag not set");

	property p_fixed;
		@(posedge mclk_i) disable iff (!arst_n_i)
		cfg_rd_i && cfg_rd_addr_i == `PFS_STATUS_OFFSET
		|=> (cfg_rd_data_o & 16'h06F7) == 16'h0230;
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed status bits wrong");

	property p_mdpar;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(!flag_w[5] && !parity_response_enable_i) |=> !flag_w[5];
	endproperty
	a_mdpar: assert property (p_mdpar)
		else $error("master data parity set with response disabled");

	property p_intx;
		@(posedge mclk_i) disable iff (!arst_n_i)
		intx_o |-> $past(int_status_q) && !$past(int_disable_i);
	endproperty
	a_intx: assert property (p_intx)
		else $error("interrupt driven while disabled or idle");

	property p_int_track;
		@(posedge mclk_i) disable iff (!arst_n_i)
		int_disable_i ##1 1'b1 |-> int_status_q == $past(int_pending_i);
	endproperty
	a_int_track: assert property (p_int_track)
		else $error("interrupt status frozen by disable");

	property p_serr_oe;
		@(posedge mclk_i) disable iff (!arst_n_i)
		serr_oe_o |-> $past(system_error_enable_i);
	endproperty
	a_serr_oe: assert property (p_serr_oe)
		else $error("system error driven while disabled");

	property p_clear;
		@(posedge mclk_i) disable iff (!arst_n_i)
		s_write_one_clear(`PFS_BIT_MSTR_ABT) |=> !flag_w[2];
	endproperty
	a_clear: assert property (p_clear)
		else $error("write one did not clear flag");

	// event qualified by its enable, as both flag and driver see it
	sequence s_serr_event;
		evt_i.serr_signaled && system_error_enable_i;
	endsequence

	// status lags the source by one edge, so the mask is checked after
	sequence s_pend_unmasked;
		int_pending_i ##1 !int_disable_i;
	endsequence

	// a write that leaves the master abort flag alone
	sequence s_keep_write;
		flag_w[2] && hit_w
		&& !(cfg_wr_i.data[`PFS_BIT_MSTR_ABT] && cfg_wr_i.be[1]);
	endsequence

	property p_sys_set;
		@(posedge mclk_i) disable iff (!arst_n_i)
		s_serr_event |=> flag_w[1];
	endproperty
	a_sys_set: assert property (p_sys_set)
		else $error("system error flag not set");

	property p_serr_pulse;
		@(posedge mclk_i) disable iff (!arst_n_i)
		s_serr_event |=> serr_oe_o;
	endproperty
	a_serr_pulse: assert property (p_serr_pulse)
		else $error("system error driver not enabled");

	property p_serr_drop;
		@(posedge mclk_i) disable iff (!arst_n_i)
		!(evt_i.serr_signaled && system_error_enable_i) |=> !serr_oe_o;
	endproperty
	a_serr_drop: assert property (p_serr_drop)
		else $error("system error driver held without cause");

	property p_par_quiet;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(!flag_w[0] && !evt_i.addr_parity_err && !evt_i.data_parity_err)
		|=> !flag_w[0];
	endproperty
	a_par_quiet: assert property (p_par_quiet)
		else $error("parity flag set without cause");

	property p_mdpar_set;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(evt_i.perr_seen && evt_i.was_bus_master
		 && parity_response_enable_i) |=> flag_w[5];
	endproperty
	a_mdpar_set: assert property (p_mdpar_set)
		else $error("master data parity flag not set");

	property p_intx_rise;
		@(posedge mclk_i) disable iff (!arst_n_i)
		s_pend_unmasked |=> intx_o;
	endproperty
	a_intx_rise: assert property (p_intx_rise)
		else $error("interrupt not driven while pending");

	property p_intx_mask;
		@(posedge mclk_i) disable iff (!arst_n_i)
		int_disable_i |=> !intx_o;
	endproperty
	a_intx_mask: assert property (p_intx_mask)
		else $error("interrupt driven while masked");

	property p_int_read;
		@(posedge mclk_i) disable iff (!arst_n_i)
		cfg_rd_i && cfg_rd_addr_i == `PFS_STATUS_OFFSET
		|=> cfg_rd_data_o[`PFS_BIT_INTSTAT] == $past(int_status_q);
	endproperty
	a_int_read: assert property (p_int_read)
		else $error("interrupt status not shown in read data");

	property p_keep;
		@(posedge mclk_i) disable iff (!arst_n_i)
		s_keep_write |=> flag_w[2];
	endproperty
	a_keep: assert property (p_keep)
		else $error("flag lost on write without a one");

	property p_clear_tr;
		@(posedge mclk_i) disable iff (!arst_n_i)
		s_write_one_clear(`PFS_BIT_TABORT_R) |=> !flag_w[3];
	endproperty
	a_clear_tr: assert property (p_clear_tr)
		else $error("write one did not clear target abort flag");
endmodule // pfs_status_reg

// file: pfs_bus_agent.sv
// bus agent model that raises event pulses toward the status register
`timescale 1ns/1ps
module pfs_bus_agent
	import pfs_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       arst_n_i,
	input  wire logic       fire_i,
	input  wire logic [7:0] kind_i,
	output pfs_event_s      evt_o
);
	// --------------------------------
	// one-cycle event pulse
	// --------------------------------
	// registered, so the pulse lasts one edge per cycle that fire_i was high
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			evt_o <= '0;
		end else begin
			evt_o <= fire_i ? pfs_event_s'(kind_i) : '0;
		end
	end
endmodule // pfs_bus_agent

// file: test_pci_function_status_register.sv
// self-checking bench for the function status register
`timescale 1ns/1ps
`include "pfs_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_pci_function_status_register
	import pfs_pkg::*;
;
	typedef struct packed {
		logic [7:0]  ev;
		logic        pen;
		logic        sen;
		logic [15:0] exp;
	} pfs_row_s;
	// --------------------------------
	// signals
	// --------------------------------
	logic        mclk = 1'h0, arst_n = 1'h0, fire = 1'h0;
	logic [7:0]  kind = 8'h00, rd_addr = 8'h00;
	logic        pend = 1'h0, pen = 1'h0, sen = 1'h0, idis = 1'h0;
	logic        rd = 1'h0, intx, serr, serr_oe;
	logic [15:0] rdata, v;
	pfs_event_s  evt;
	pfs_cfg_wr_s cw = '0;
	int          fails = 0, n_compared = 0;
	pfs_row_s    rows [10] = '{
		'{8'h80, 1'h0, 1'h0, 16'h8230}, '{8'h40, 1'h0, 1'h0, 16'h8230},
		'{8'h20, 1'h0, 1'h1, 16'h4230}, '{8'h20, 1'h0, 1'h0, 16'h0230},
		'{8'h10, 1'h0, 1'h0, 16'h2230}, '{8'h08, 1'h0, 1'h0, 16'h1230},
		'{8'h04, 1'h0, 1'h0, 16'h0A30}, '{8'h03, 1'h1, 1'h0, 16'h0330},
		'{8'h03, 1'h0, 1'h0, 16'h0230}, '{8'h02, 1'h1, 1'h0, 16'h0230}};
	always #25 mclk = ~mclk;
	pfs_bus_agent i_agent (.mclk_i(mclk), .arst_n_i(arst_n), .fire_i(fire),
		.kind_i(kind), .evt_o(evt));
	pfs_status_reg i_dut (.mclk_i(mclk), .arst_n_i(arst_n), .evt_i(evt),
		.int_pending_i(pend), .parity_response_enable_i(pen),
		.system_error_enable_i(sen), .int_disable_i(idis), .cfg_wr_i(cw),
		.cfg_rd_i(rd), .cfg_rd_addr_i(rd_addr), .cfg_rd_data_o(rdata),
		.intx_o(intx), .serr_o(serr), .serr_oe_o(serr_oe));
	// --------------------------------
	// bus tasks
	// --------------------------------
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk); #1 rd = 1'h1; rd_addr = a;
		@(posedge mclk); #1 rd = 1'h0;
		d = rdata;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [1:0] be,
		input logic [15:0] d);
		@(posedge mclk); #1 cw = '{1'h1, a, be, d};
		@(posedge mclk); #1 cw.wr = 1'h0;
	endtask
	task automatic fire_evt(input logic [7:0] k);
		@(posedge mclk); #1 fire = 1'h1; kind = k;
		@(posedge mclk); #1 fire = 1'h0;
		@(posedge mclk); #1;
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// --------------------------------
	// watchdog and main sequence
	// --------------------------------
	initial begin
		repeat (5000) @(posedge mclk);
		fails++;
		tally_and_finish();
	end
	initial begin
		repeat (6) @(posedge mclk);
		#1 `CHK({intx, serr, serr_oe, rdata}, 19'h0)
		arst_n = 1'h1;
		rd_reg(8'h06, v);
		`CHK(v, 16'h0230)
		$display("test reset done");
		// flags cleared by writing ones after every row
		foreach (rows[i]) begin
			pen = rows[i].pen;
			sen = rows[i].sen;
			fire_evt(rows[i].ev);
			`CHK(serr_oe, rows[i].ev[5] & rows[i].sen)
			`CHK(serr, 1'h0)
			rd_reg(8'h06, v);
			`CHK(v, rows[i].exp)
			wr_reg(8'h06, 2'h3, 16'hFFFF);
			rd_reg(8'h06, v);
			`CHK(v, 16'h0230)
		end
		$display("test event table done");
		sen = 1'h1;
		fire_evt(8'hFF);
		wr_reg(8'h06, 2'h3, 16'h0000);
		wr_reg(8'h06, 2'h1, 16'hFFFF);
		wr_reg(8'h04, 2'h3, 16'hFFFF);
		rd_reg(8'h06, v);
		`CHK(v, 16'hFB30)
		rd_reg(8'h04, v);
		`CHK(v, 16'h0000)
		wr_reg(8'h06, 2'h2, 16'h2000);
		rd_reg(8'h06, v);
		`CHK(v, 16'hDB30)
		wr_reg(8'h06, 2'h2, 16'hFF00);
		$display("test write lanes done");
		// event and clearing write land on the same edge
		@(posedge mclk); #1 fire = 1'h1; kind = 8'h10;
		@(posedge mclk); #1 fire = 1'h0; cw = '{1'h1, 8'h06, 2'h3, 16'hFFFF};
		@(posedge mclk); #1 cw.wr = 1'h0;
		rd_reg(8'h06, v);
		`CHK(v, 16'h2230)
		wr_reg(8'h06, 2'h3, 16'hFFFF);
		$display("test set wins done");
		pend = 1'h1;
		repeat (3) @(posedge mclk);
		#1 `CHK(intx, 1'h1)
		idis = 1'h1;
		repeat (3) @(posedge mclk);
		#1 `CHK(intx, 1'h0)
		rd_reg(8'h06, v);
		`CHK(v, 16'h0238)
		pend = 1'h0;
		repeat (3) @(posedge mclk);
		rd_reg(8'h06, v);
		`CHK(v, 16'h0230)
		idis = 1'h0;
		repeat (3) @(posedge mclk);
		#1 `CHK(intx, 1'h0)
		$display("test interrupt done");
		tally_and_finish();
	end
endmodule // test_pci_function_status_register
